// ### csl_pkg.sv
// constants, types and decode table of the clock strap latch and select block
package csl_pkg;

   // ****************************************
   // register bus
   // ****************************************
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;

   localparam logic [6:0] REG_CTRL0   = 7'h00;
   localparam logic [6:0] REG_CTRL1   = 7'h01;
   localparam logic [6:0] REG_OE_HI   = 7'h03;
   localparam logic [6:0] REG_OE_LO   = 7'h04;
   localparam logic [6:0] REG_PIN_MAP = 7'h05;
   localparam logic [6:0] REG_MGMT    = 7'h0b;
   localparam logic [6:0] REG_ADDR    = 7'h0c;
   localparam logic [6:0] REG_STRAP   = 7'h0d;

   localparam logic [7:0] SLAVE_WR_ADDR = 8'hd2;
   localparam int unsigned CMD_BYTE_BIT = 7;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_CTRL0   = 8'h01;
   localparam logic [7:0] RST_CTRL1   = 8'h03;
   localparam logic [7:0] RST_OE_HI   = 8'hff;
   localparam logic [7:0] RST_OE_LO   = 8'hfe;
   localparam logic [7:0] RST_PIN_MAP = 8'h00;
   localparam logic [7:0] RST_MGMT    = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int unsigned CTRL0_MGMT_EN   = 4;
   localparam int unsigned CTRL1_DISP_SEL  = 7;
   localparam int unsigned OE_LO_CPU0      = 2;
   localparam int unsigned OE_LO_CPU1      = 3;
   localparam int unsigned MAP_A_TO_2      = 0;
   localparam int unsigned MAP_B_TO_4      = 1;
   localparam int unsigned MAP_A_INPUT     = 2;
   localparam int unsigned MAP_B_INPUT     = 3;
   localparam int unsigned MAP_C7_INPUT    = 4;
   localparam int unsigned MGMT_LSB        = 2;

   // ****************************************
   // processor clock frequencies in MHz
   // ****************************************
   localparam logic [8:0] MHZ_100 = 9'h064;
   localparam logic [8:0] MHZ_133 = 9'h085;
   localparam logic [8:0] MHZ_166 = 9'h0a6;
   localparam logic [8:0] MHZ_200 = 9'h0c8;
   localparam logic [8:0] MHZ_266 = 9'h10a;
   localparam logic [8:0] MHZ_333 = 9'h14d;
   localparam logic [8:0] MHZ_400 = 9'h190;

   // synchronised pin inputs, in the order they are sampled
   typedef struct packed {
      logic       pg;
      logic [3:0] fs;
      logic       stop_strap;
      logic       dbg_strap;
      logic       test_level;
      logic       proc_stop_n;
      logic       periph_stop_n;
      logic       oe02_a_n;
      logic       oe02_b_n;
      logic       oe14_a_n;
      logic       oe14_b_n;
      logic       oe6_n;
      logic       oe8_n;
   } csl_pins_type;

   localparam int unsigned PINS_W = $bits(csl_pins_type);

   function automatic logic [8:0] csl_freq_mhz(input logic [2:0] sel);
      logic [8:0] f;
      f = MHZ_200;
      unique case (sel)
         3'h5: f = MHZ_100;
         3'h1: f = MHZ_133;
         3'h3: f = MHZ_166;
         3'h2: f = MHZ_200;
         3'h0: f = MHZ_266;
         3'h4: f = MHZ_333;
         3'h6: f = MHZ_400;
         3'h7: f = MHZ_200;
      endcase
      return f;
   endfunction

endpackage

// ### csl_strap_if.sv
// interface carrying synchronised pins and latched straps
`timescale 1ns/10ps
interface csl_strap_if;
   csl_pkg::csl_pins_type pins;
   logic                  latched;
   logic [3:0]            fs_q;
   logic                  stop_q;
   logic                  dbg_q;
   logic                  test_q;

   modport latch (
      input  pins,
      output latched,
      output fs_q,
      output stop_q,
      output dbg_q,
      output test_q
   );

   modport user (
      output pins,
      input  latched,
      input  fs_q,
      input  stop_q,
      input  dbg_q,
      input  test_q
   );
endinterface

// ### csl_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module csl_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   // pins
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } csl_sync_type;

   csl_sync_type st;
   csl_sync_type next_st;

   always_comb begin
      next_st    = st;
      next_st.s1 = d_i;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.s2;

endmodule

// ### csl_strap_latch.sv
// one-shot strap latch on the power-good strobe
`timescale 1ns/10ps
module csl_strap_latch (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic srst_i,
   // straps
   csl_strap_if.latch sif
);

   typedef struct packed {
      logic       latched;
      logic [3:0] fs;
      logic       stop;
      logic       dbg;
      logic       test;
   } csl_latch_type;

   csl_latch_type st;
   csl_latch_type next_st;

   always_comb begin
      next_st = st;
      if (!st.latched && sif.pins.pg) begin
         // first high level takes every strap at once
         next_st.latched = 1'b1;
         next_st.fs      = sif.pins.fs;
         next_st.stop    = sif.pins.stop_strap;
         next_st.dbg     = sif.pins.dbg_strap;
         next_st.test    = sif.pins.test_level;
      end else if (st.latched && st.test && sif.pins.pg) begin
         // only test mode follows the select pins afterwards
         next_st.fs = sif.pins.fs;
      end
      // pin functions stay put until the next power-up
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sif.latched = st.latched;
   assign sif.fs_q    = st.fs;
   assign sif.stop_q  = st.stop;
   assign sif.dbg_q   = st.dbg;
   assign sif.test_q  = st.test;

   property p_one_shot;
      @(posedge clk_i) disable iff (srst_i)
      st.latched && !st.test |=> $stable(st.fs) && $stable(st.stop)
                                 && $stable(st.dbg) && st.latched;
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("latched straps changed outside test mode");

endmodule

// ### csl_top.sv
// strap latching, frequency decode and output function select
`timescale 1ns/10ps
module csl_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // register port
   input  wire logic [6:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic      [7:0]  rdata_o,
   // strap and power pins
   input  wire logic        power_good_strobe_i,
   input  wire logic        freq_select_0_i,
   input  wire logic        freq_select_1_i,
   input  wire logic        freq_select_2_i,
   input  wire logic        freq_select_3_i,
   input  wire logic        stop_pin_strap_i,
   input  wire logic        debug_clock_strap_i,
   input  wire logic        test_select_high_i,
   // shared input pins
   input  wire logic        proc_stop_n_i,
   input  wire logic        periph_stop_n_i,
   input  wire logic        oe02_a_n_i,
   input  wire logic        oe02_b_n_i,
   input  wire logic        oe14_a_n_i,
   input  wire logic        oe14_b_n_i,
   input  wire logic        oe6_n_i,
   input  wire logic        oe8_n_i,
   // shared pin drive enables
   output logic             oe02_pins_drive_o,
   output logic             oe14_pins_drive_o,
   output logic             stop_pins_drive_o,
   output logic             clk7_pins_drive_o,
   // clock control
   output logic [8:0]       proc_freq_mhz_o,
   output logic [2:0]       proc_clk_en_o,
   output logic [11:0]      serial_ref_clock_en_o,
   output logic             pci_clk_en_o,
   output logic             display_96_clock_sel_o,
   output logic             proc_debug_clock_sel_o,
   output logic             power_down_o,
   output logic             straps_latched_o,
   output logic             test_tristate_o,
   output logic             test_ref_div_o
);

   // ****************************************
   // pin synchronisers and strap latch
   // ****************************************
   csl_strap_if sif ();

   logic [csl_pkg::PINS_W-1:0] pins_raw;
   logic [csl_pkg::PINS_W-1:0] pins_sync;

   assign pins_raw = {power_good_strobe_i, freq_select_3_i, freq_select_2_i,
                      freq_select_1_i, freq_select_0_i, stop_pin_strap_i,
                      debug_clock_strap_i, test_select_high_i, proc_stop_n_i,
                      periph_stop_n_i, oe02_a_n_i, oe02_b_n_i, oe14_a_n_i,
                      oe14_b_n_i, oe6_n_i, oe8_n_i};

   csl_sync #(
      .W (csl_pkg::PINS_W)
   ) u_sync (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .d_i    (pins_raw),
      .q_o    (pins_sync)
   );

   assign sif.pins = csl_pkg::csl_pins_type'(pins_sync);

   csl_strap_latch u_latch (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .sif    (sif)
   );

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0]  ctrl0;
      logic [7:0]  ctrl1;
      logic [7:0]  oe_hi;
      logic [7:0]  oe_lo;
      logic [7:0]  pin_map;
      logic [7:0]  mgmt;
      logic [7:0]  rdata;
      logic [3:0]  pin_drive;
      logic [8:0]  mhz;
      logic [2:0]  proc_en;
      logic [11:0] src_en;
      logic        pci_en;
      logic        disp_sel;
      logic        dbg_sel;
      logic        pd;
      logic        tri_st;
      logic        ref_div;
   } csl_top_type;

   csl_top_type st;
   csl_top_type next_st;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic       stop_in;
      logic       proc_stop;
      logic       periph_stop;
      logic       run;
      logic       mgmt_on;
      logic       a_in;
      logic       b_in;
      logic       c7_in;
      logic       a_gate;
      logic       b_gate;
      logic [7:0] rd;
      stop_in     = 1'b0;
      proc_stop   = 1'b0;
      periph_stop = 1'b0;
      run         = 1'b0;
      mgmt_on     = 1'b0;
      a_in        = 1'b0;
      b_in        = 1'b0;
      c7_in       = 1'b0;
      a_gate      = 1'b0;
      b_gate      = 1'b0;
      rd          = 8'h00;
      next_st     = st;

      // writes land at the byte offset of the command code
      if (we_i) begin
         unique case (addr_i)
            csl_pkg::REG_CTRL0: begin
               // management enable is sticky once set
               next_st.ctrl0 = wdata_i |
                  (st.ctrl0 & (8'h01 << csl_pkg::CTRL0_MGMT_EN));
            end
            csl_pkg::REG_CTRL1:   next_st.ctrl1   = wdata_i;
            csl_pkg::REG_OE_HI:   next_st.oe_hi   = wdata_i;
            csl_pkg::REG_OE_LO:   next_st.oe_lo   = wdata_i;
            csl_pkg::REG_PIN_MAP: next_st.pin_map = wdata_i;
            csl_pkg::REG_MGMT:    next_st.mgmt    = wdata_i;
            default: ;
         endcase
      end

      // read data stand for one cycle only
      unique case (addr_i)
         csl_pkg::REG_CTRL0: rd = {sif.fs_q[2], sif.fs_q[1], sif.fs_q[0],
                                   st.ctrl0[4:0]};
         csl_pkg::REG_CTRL1:   rd = st.ctrl1;
         csl_pkg::REG_OE_HI:   rd = st.oe_hi;
         csl_pkg::REG_OE_LO:   rd = st.oe_lo;
         csl_pkg::REG_PIN_MAP: rd = st.pin_map;
         csl_pkg::REG_MGMT:    rd = st.mgmt;
         csl_pkg::REG_ADDR:    rd = csl_pkg::SLAVE_WR_ADDR;
         csl_pkg::REG_STRAP:   rd = {sif.latched, sif.test_q, sif.stop_q,
                                     sif.dbg_q, sif.fs_q};
         default:              rd = 8'h00;
      endcase
      next_st.rdata = re_i ? rd : 8'h00;
      // stop pin function picked by the latched strap, mappable pins by the pin map register
      stop_in = sif.latched && !sif.stop_q;
      a_in    = st.pin_map[csl_pkg::MAP_A_INPUT];
      b_in    = st.pin_map[csl_pkg::MAP_B_INPUT];
      c7_in   = st.pin_map[csl_pkg::MAP_C7_INPUT];
      mgmt_on = st.ctrl0[csl_pkg::CTRL0_MGMT_EN];
      proc_stop   = stop_in && !sif.pins.proc_stop_n;
      periph_stop = stop_in && !sif.pins.periph_stop_n;
      // pin doubles as power-down request once latched
      next_st.pd = sif.latched && !sif.pins.pg;
      run = sif.latched && sif.pins.pg && !sif.test_q;
      next_st.mhz = csl_pkg::csl_freq_mhz(sif.fs_q[2:0]);
      // test mode: select-B pin picks tri-state or ref/N
      next_st.tri_st  = sif.test_q && !sif.pins.fs[1];
      next_st.ref_div = sif.test_q && sif.pins.fs[1];
      // processor clocks; clocks 1 and 2 follow management field while management enable is set, else oe_lo and oe_hi bits
      next_st.proc_en[0] = run && !proc_stop
                           && st.oe_lo[csl_pkg::OE_LO_CPU0];
      next_st.proc_en[1] = run && !proc_stop
                           && (mgmt_on ? st.mgmt[csl_pkg::MGMT_LSB]
                                       : st.oe_lo[csl_pkg::OE_LO_CPU1]);
      next_st.proc_en[2] = run && !proc_stop && sif.dbg_q
                           && (mgmt_on ? st.mgmt[csl_pkg::MGMT_LSB + 1]
                                       : st.oe_hi[4]);
      // mappable output-enable pins, enabled while low
      a_gate = a_in && (sif.pins.oe02_a_n || sif.pins.oe02_b_n);
      b_gate = b_in && (sif.pins.oe14_a_n || sif.pins.oe14_b_n);
      next_st.src_en = {st.oe_hi, st.oe_lo[7:4]};
      if (a_gate) begin
         next_st.src_en[st.pin_map[csl_pkg::MAP_A_TO_2] ? 2 : 0] = 1'b0;
      end
      if (b_gate) begin
         next_st.src_en[st.pin_map[csl_pkg::MAP_B_TO_4] ? 4 : 1] = 1'b0;
      end
      // group pins used as inputs lose clock 3
      if (a_in || b_in) begin
         next_st.src_en[3] = 1'b0;
      end
      // clock 5 exists only when the stop pins are outputs
      if (!sif.stop_q) begin
         next_st.src_en[5] = 1'b0;
      end
      // clock-7 pins as enables for clocks 6 and 8
      if (c7_in) begin
         next_st.src_en[7] = 1'b0;
         if (sif.pins.oe6_n) begin
            next_st.src_en[6] = 1'b0;
         end
         if (sif.pins.oe8_n) begin
            next_st.src_en[8] = 1'b0;
         end
      end
      // pair 8 belongs to the debug clock when strapped so
      if (sif.dbg_q) begin
         next_st.src_en[8] = 1'b0;
      end
      if (!run || periph_stop) begin
         next_st.src_en = 12'h000;
      end
      next_st.pci_en = run && !periph_stop;
      next_st.disp_sel = st.ctrl1[csl_pkg::CTRL1_DISP_SEL];
      next_st.dbg_sel  = sif.latched && sif.dbg_q;
      // drive enables of the shared pins; all released in test tri-state
      next_st.pin_drive[0] = !a_in;
      next_st.pin_drive[1] = !b_in;
      next_st.pin_drive[2] = sif.latched && sif.stop_q;
      next_st.pin_drive[3] = !c7_in;
      if (next_st.tri_st) begin
         next_st.pin_drive = 4'h0;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         // power-up defaults
         st         <= '0;
         st.ctrl0   <= csl_pkg::RST_CTRL0;
         st.ctrl1   <= csl_pkg::RST_CTRL1;
         st.oe_hi   <= csl_pkg::RST_OE_HI;
         st.oe_lo   <= csl_pkg::RST_OE_LO;
         st.pin_map <= csl_pkg::RST_PIN_MAP;
         st.mgmt    <= csl_pkg::RST_MGMT;
      end else begin
         // power-down leaves configuration untouched
         st <= next_st;
      end
   end

   assign rdata_o                = st.rdata;
   assign oe02_pins_drive_o      = st.pin_drive[0];
   assign oe14_pins_drive_o      = st.pin_drive[1];
   assign stop_pins_drive_o      = st.pin_drive[2];
   assign clk7_pins_drive_o      = st.pin_drive[3];
   assign proc_freq_mhz_o        = st.mhz;
   assign proc_clk_en_o          = st.proc_en;
   assign serial_ref_clock_en_o  = st.src_en;
   assign pci_clk_en_o           = st.pci_en;
   assign display_96_clock_sel_o = st.disp_sel;
   assign proc_debug_clock_sel_o = st.dbg_sel;
   assign power_down_o           = st.pd;
   assign straps_latched_o       = sif.latched;
   assign test_tristate_o        = st.tri_st;
   assign test_ref_div_o         = st.ref_div;

   // ****************************************
   // assertions
   // ****************************************
   property p_freq;
      @(posedge clk_i) disable iff (srst_i)
      sif.latched |=> proc_freq_mhz_o
                      == csl_pkg::csl_freq_mhz($past(sif.fs_q[2:0]));
   endproperty
   a_freq: assert property (p_freq)
      else $error("processor frequency does not match latched code");
   property p_pd;
      @(posedge clk_i) disable iff (srst_i)
      sif.latched && !sif.pins.pg |=> power_down_o && !pci_clk_en_o;
   endproperty
   a_pd: assert property (p_pd)
      else $error("power-down request not honoured");
   property p_stop_pins;
      @(posedge clk_i) disable iff (srst_i)
      sif.latched && !sif.test_q |=> stop_pins_drive_o == $past(sif.stop_q);
   endproperty
   a_stop_pins: assert property (p_stop_pins)
      else $error("stop pin function does not follow strap");
   property p_dbg;
      @(posedge clk_i) disable iff (srst_i)
      sif.latched && sif.dbg_q |=> !serial_ref_clock_en_o[8]
                                    && proc_debug_clock_sel_o;
   endproperty
   a_dbg: assert property (p_dbg)
      else $error("clock 8 driven while debug clock selected");
   property p_proc_stop;
      @(posedge clk_i) disable iff (srst_i)
      sif.latched && !sif.stop_q && !sif.pins.proc_stop_n
         |=> proc_clk_en_o == 3'h0;
   endproperty
   a_proc_stop: assert property (p_proc_stop)
      else $error("processor clocks run during processor stop");
   property p_periph_stop;
      @(posedge clk_i) disable iff (srst_i)
      sif.latched && !sif.stop_q && !sif.pins.periph_stop_n
         |=> !pci_clk_en_o && serial_ref_clock_en_o == 12'h000;
   endproperty
   a_periph_stop: assert property (p_periph_stop)
      else $error("peripheral clocks run during peripheral stop");
   property p_test;
      @(posedge clk_i) disable iff (srst_i)
      sif.test_q && !sif.pins.fs[1] |=> test_tristate_o && !test_ref_div_o
                                        && !clk7_pins_drive_o;
   endproperty
   a_test: assert property (p_test)
      else $error("test tri-state not applied");
   property p_disp;
      @(posedge clk_i) disable iff (srst_i)
      we_i && addr_i == csl_pkg::REG_CTRL1
         |-> ##2 display_96_clock_sel_o == $past(wdata_i[7], 2);
   endproperty
   a_disp: assert property (p_disp)
      else $error("display clock select not taken from write");
   property p_oe_map;
      @(posedge clk_i) disable iff (srst_i)
      st.pin_map[csl_pkg::MAP_A_INPUT] && !st.pin_map[csl_pkg::MAP_A_TO_2]
         && sif.pins.oe02_a_n |=> !serial_ref_clock_en_o[0];
   endproperty
   a_oe_map: assert property (p_oe_map)
      else $error("mapped enable pin did not gate clock 0");

endmodule

// ### csl_board_model.sv
// board model: strap resistors and power-good source
`timescale 1ns/10ps
module csl_board_model (
   // clock
   input  wire logic       clk_i,
   // requests from the bench
   input  wire logic       pg_req_i,
   input  wire logic [6:0] strap_i,
   // pins towards the device
   output logic      [6:0] strap_o,
   output logic            pg_o
);
   logic [6:0] last = '0;
   logic [2:0] cnt  = '0;
   logic       pg   = 1'b0;
   assign strap_o = strap_i;
   assign pg_o    = pg;
   // power good rises only after straps held still four cycles
   always @(posedge clk_i) begin
      last <= strap_i;
      if (strap_i !== last) cnt <= 3'h0;
      else if (cnt != 3'h4) cnt <= cnt + 3'h1;
      pg <= pg_req_i & (pg | (cnt == 3'h4));
   end
endmodule

// ### clock_strap_latch_and_select_tb.sv
// self-checking bench of the strap latch and select block
`timescale 1ns/10ps
module clock_strap_latch_and_select_tb;
   logic clk_i, srst_i, we_i, re_i, pg_req, power_good_strobe_i;
   logic proc_stop_n_i, periph_stop_n_i, oe02_a_n_i, oe6_n_i, oe8_n_i;
   logic oe02_b_n_i, oe14_a_n_i, oe14_b_n_i, oe02_pins_drive_o;
   logic oe14_pins_drive_o, clk7_pins_drive_o;
   logic [6:0] addr_i, sp, spo;
   logic [7:0] wdata_i, rdata_o, d;
   logic stop_pins_drive_o, pci_clk_en_o, display_96_clock_sel_o;
   logic proc_debug_clock_sel_o, power_down_o, straps_latched_o;
   logic test_tristate_o, test_ref_div_o;
   logic [8:0] proc_freq_mhz_o;
   logic [2:0] proc_clk_en_o;
   logic [11:0] serial_ref_clock_en_o;
   logic [31:0] rnd = 32'ha388;
   int error_cnt = 0;
   int comparisons = 0;
   logic [6:0] ra [7] = '{7'h01,7'h03,7'h04,7'h05,7'h0b,7'h0c,7'h02};
   logic [7:0] rv [7] = '{8'h03,8'hff,8'hfe,8'h00,8'h00,8'hd2,8'h00};
   logic [8:0] ft [8] = '{9'h10a,9'h085,9'h0c8,9'h0a6,
                          9'h14d,9'h064,9'h190,9'h0c8};
   csl_board_model board (.clk_i(clk_i), .pg_req_i(pg_req), .strap_i(sp),
      .strap_o(spo), .pg_o(power_good_strobe_i));
   csl_top dut (.clk_i, .srst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
      .power_good_strobe_i, .freq_select_0_i(spo[0]),
      .freq_select_1_i(spo[1]), .freq_select_2_i(spo[2]),
      .freq_select_3_i(spo[3]), .debug_clock_strap_i(spo[4]),
      .stop_pin_strap_i(spo[5]), .test_select_high_i(spo[6]),
      .proc_stop_n_i, .periph_stop_n_i, .oe02_a_n_i, .oe02_b_n_i,
      .oe14_a_n_i, .oe14_b_n_i, .oe6_n_i, .oe8_n_i,
      .oe02_pins_drive_o, .oe14_pins_drive_o, .stop_pins_drive_o,
      .clk7_pins_drive_o, .proc_freq_mhz_o, .proc_clk_en_o,
      .serial_ref_clock_en_o, .pci_clk_en_o, .display_96_clock_sel_o,
      .proc_debug_clock_sel_o, .power_down_o, .straps_latched_o,
      .test_tristate_o, .test_ref_div_o);
   // ****************************************
   // tasks
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [8:0] exp_mhz(input logic [2:0] s);
      return ft[s];
   endfunction
   task stop_test;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask
   task rd(input logic [6:0] a);
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task pu(input logic [6:0] v);
      srst_i <= 1'b1;
      pg_req <= 1'b0;
      sp <= v;
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      pg_req <= 1'b1;
      cyc(14);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #400000;
      error_cnt++;
      stop_test;
   end
   initial begin
      {srst_i, we_i, re_i, pg_req, addr_i, wdata_i, sp} = '0;
      {proc_stop_n_i, periph_stop_n_i} = 2'b11;
      {oe02_a_n_i, oe02_b_n_i, oe14_a_n_i, oe14_b_n_i, oe6_n_i, oe8_n_i} = '0;
      for (int i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         pu({1'b0, i[0], i[1], rnd[0], i[2:0]});
         chk(proc_freq_mhz_o, exp_mhz(i[2:0]));
         chk(straps_latched_o, 1);
         chk(stop_pins_drive_o, i[0]);
         chk(proc_debug_clock_sel_o, i[1]);
         rd(7'h0d);
         chk(d, {1'b1, sp});
         if (!i[0]) begin
            proc_stop_n_i <= 1'b0;
            cyc(4);
            chk(proc_clk_en_o, 0);
            proc_stop_n_i <= 1'b1;
            periph_stop_n_i <= 1'b0;
            cyc(4);
            chk(pci_clk_en_o, 0);
            chk(serial_ref_clock_en_o, 0);
            periph_stop_n_i <= 1'b1;
            cyc(4);
            chk(pci_clk_en_o, 1);
         end
         if (i == 0) begin
            wr(7'h02, 8'hff);
            wr(7'h0c, 8'h00);
            for (int k = 0; k < 7; k++) begin
               rd(ra[k]);
               chk(d, rv[k]);
            end
         end
         rnd = xs(rnd);
         sp[5:0] <= rnd[5:0];
         cyc(5);
         chk(proc_freq_mhz_o, exp_mhz(i[2:0]));
         chk(proc_debug_clock_sel_o, i[1]);
         chk(stop_pins_drive_o, i[0]);
      end
      wr(7'h01, 8'h80);
      cyc(2);
      chk(display_96_clock_sel_o, 1);
      pg_req <= 1'b0;
      cyc(6);
      chk(power_down_o, 1);
      chk(pci_clk_en_o, 0);
      pg_req <= 1'b1;
      cyc(12);
      chk(power_down_o, 0);
      rd(7'h01);
      chk(d, 8'h80);
      wr(7'h00, 8'h11);
      wr(7'h0b, 8'h00);
      cyc(3);
      chk(proc_clk_en_o, 3'h1);
      wr(7'h0b, 8'h0c);
      cyc(3);
      chk(proc_clk_en_o, 3'h7);
      wr(7'h00, 8'h01);
      rd(7'h00);
      chk(d, 8'hf1);
      wr(7'h05, 8'h15);
      {oe02_b_n_i, oe14_a_n_i, oe6_n_i} <= 3'b111;
      cyc(4);
      chk(serial_ref_clock_en_o[2], 0);
      chk(serial_ref_clock_en_o[0], 1);
      chk(serial_ref_clock_en_o[1], 1);
      chk(serial_ref_clock_en_o[6], 0);
      chk({oe02_pins_drive_o, oe14_pins_drive_o}, 2'b01);
      chk(clk7_pins_drive_o, 0);
      {oe02_b_n_i, oe14_a_n_i, oe6_n_i} <= 3'b000;
      cyc(4);
      chk(serial_ref_clock_en_o[2], 1);
      chk(serial_ref_clock_en_o[6], 1);
      pu(7'h20);
      wr(7'h05, 8'h1e);
      {oe02_a_n_i, oe14_b_n_i, oe8_n_i} <= 3'b111;
      cyc(4);
      chk(serial_ref_clock_en_o, 12'he66);
      {oe02_a_n_i, oe14_b_n_i, oe8_n_i} <= 3'b000;
      cyc(4);
      chk(serial_ref_clock_en_o, 12'hf77);
      pu(7'h40);
      chk(test_tristate_o, 1);
      sp[1] <= 1'b1;
      cyc(5);
      chk(test_ref_div_o, 1);
      chk(test_tristate_o, 0);
      chk(proc_freq_mhz_o, exp_mhz(3'h2));
      stop_test;
   end
endmodule
